// file: axdec_in_sync.sv
// Constants of the auxiliary encoder decoder and its input synchroniser.
// Assumes channel A and B arrive from pins, asynchronous to clock.
// Behaviour
// R1 - Selectable input type, quadrature x4 after reset
// R2 - Quadrature counts every edge of both channels; edges of A and B that fall in one cycle count nothing
// R3 - Step mode: A pulses, B gives direction
// R4 - Up/down mode: A pulses up, B down
// R5 - Quadrature counts up when A leads B
// R6 - Step mode counts up while B high
// R7 - Up/down mode counts up on A pulses
// R8 - Opposite conditions count the position down
package axdec_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_TYPE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_POS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam int DATA_W = 32;
  localparam int MODE_W = 2;
  localparam logic [MODE_W-1:0] QUAD_TIMES_FOUR_MODE = 2'h0;
  localparam logic [MODE_W-1:0] STEP_AND_DIRECTION_MODE = 2'h1;
  localparam logic [MODE_W-1:0] UP_DOWN_PULSE_MODE = 2'h2;
  localparam logic [MODE_W-1:0] TYPE_RESET = QUAD_TIMES_FOUR_MODE;
  localparam logic [DATA_W-1:0] POS_RESET = 32'h0000_0000;
  localparam int STAT_LEVEL_A = 0;
  localparam int STAT_LEVEL_B = 1;
  localparam int STAT_DIR_UP = 2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

module axdec_in_sync (
  input wire logic clock,
  input wire logic rstSyncN,
  input wire logic chanA,
  input wire logic chanB,
  output logic levelA,
  output logic levelB,
  output logic prevA,
  output logic prevB
);
  import axdec_pkg::*;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] level;
    logic [1:0] prev;
  } axdec_sync_t;

  axdec_sync_t state_reg;
  axdec_sync_t state_next;

  // The first stage feeds only the second stage
  always_comb begin
    state_next = state_reg;
    state_next.meta = {chanB, chanA};
    state_next.level = state_reg.meta;
    state_next.prev = state_reg.level;
  end

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign levelA = state_reg.level[0];
  assign levelB = state_reg.level[1];
  assign prevA = state_reg.prev[0];
  assign prevB = state_reg.prev[1];
endmodule

// file: axdec_decoder.sv
// Auxiliary encoder input decoder with an AHB-Lite register slave.
// Assumes one 100 MHz clock, single-word AHB-Lite transfers, and
// channels that stay stable for at least two clock periods per level.
module axdec_decoder (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic chanA,
  input wire logic chanB,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import axdec_pkg::*;

  typedef struct packed {
    logic [MODE_W-1:0] auxInputTypeSelect;
    logic [DATA_W-1:0] auxPositionCount;
    logic dirUp;
    logic wrPend;
    logic [ADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] rdData;
    logic readyOut;
    logic respOut;
  } axdec_state_t;

  axdec_state_t state_reg;
  axdec_state_t state_next;
  logic [1:0] rstSync;
  logic rstSyncN;
  logic levelA;
  logic levelB;
  logic prevA;
  logic prevB;

  // Reset enters asynchronously but is released on the clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstSyncN = rstSync[1];

  axdec_in_sync inSync (
    .clock(clock),
    .rstSyncN(rstSyncN),
    .chanA(chanA),
    .chanB(chanB),
    .levelA(levelA),
    .levelB(levelB),
    .prevA(prevA),
    .prevB(prevB)
  );

  logic riseA;
  logic riseB;
  logic changeA;
  logic changeB;
  logic stepUp;
  logic stepDown;
  logic addrPhase;
  logic [ADDR_W-1:0] addrLow;
  logic [MODE_W-1:0] typeSeen;
  logic [DATA_W-1:0] statusWord;

  assign riseA = levelA & ~prevA;
  assign riseB = levelB & ~prevB;
  assign changeA = levelA ^ prevA;
  assign changeB = levelB ^ prevB;

  // Step decode per selected input type
  always_comb begin
    stepUp = 1'b0;
    stepDown = 1'b0;
    unique case (state_reg.auxInputTypeSelect)
      QUAD_TIMES_FOUR_MODE: begin
        // Every single edge of A or B is one count; a double change
        // in one cycle has lost its order and is dropped
        if (changeA ^ changeB) begin // R2
          stepUp = ~(prevA ^ levelB); // R5
          stepDown = prevA ^ levelB; // R8
        end
      end
      STEP_AND_DIRECTION_MODE: begin
        if (riseA) begin // R3
          stepUp = levelB; // R6
          stepDown = ~levelB; // R8
        end
      end
      UP_DOWN_PULSE_MODE: begin
        // Pulses on both channels in one cycle cancel out
        stepUp = riseA & ~riseB; // R4 R7
        stepDown = riseB & ~riseA; // R4 R8
      end
      default: begin
        // Reserved type code counts nothing
        stepUp = 1'b0;
        stepDown = 1'b0;
      end
    endcase
  end

  assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign addrLow = haddr[ADDR_W-1:0];

  // A type write still in its data phase is forwarded to a read
  always_comb begin
    typeSeen = state_reg.auxInputTypeSelect;
    if (state_reg.wrPend && state_reg.wrAddr == OFS_TYPE) begin
      typeSeen = hwdata[MODE_W-1:0];
    end
  end

  always_comb begin
    statusWord = '0;
    statusWord[STAT_LEVEL_A] = levelA;
    statusWord[STAT_LEVEL_B] = levelB;
    statusWord[STAT_DIR_UP] = state_reg.dirUp;
  end

  always_comb begin
    state_next = state_reg;
    state_next.readyOut = 1'b1;
    state_next.respOut = 1'b0;
    if (stepUp) begin
      state_next.auxPositionCount = state_reg.auxPositionCount + 32'h1;
      state_next.dirUp = 1'b1;
    end else if (stepDown) begin
      state_next.auxPositionCount = state_reg.auxPositionCount - 32'h1;
      state_next.dirUp = 1'b0;
    end
    if (state_reg.wrPend && state_reg.wrAddr == OFS_TYPE) begin
      state_next.auxInputTypeSelect = hwdata[MODE_W-1:0]; // R1
    end
    state_next.wrPend = addrPhase & hwrite;
    state_next.wrAddr = addrLow;
    if (addrPhase && !hwrite) begin
      unique case (addrLow)
        OFS_TYPE: state_next.rdData = {{(DATA_W-MODE_W){1'b0}}, typeSeen};
        OFS_POS: state_next.rdData = state_next.auxPositionCount;
        OFS_STATUS: state_next.rdData = statusWord;
        default: state_next.rdData = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_reg.auxInputTypeSelect <= TYPE_RESET; // R1
      state_reg.auxPositionCount <= POS_RESET;
      state_reg.dirUp <= 1'b0;
      state_reg.wrPend <= 1'b0;
      state_reg.wrAddr <= '0;
      state_reg.rdData <= '0;
      state_reg.readyOut <= 1'b1;
      state_reg.respOut <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hrdata = state_reg.rdData;
  assign hreadyout = state_reg.readyOut;
  assign hresp = state_reg.respOut;
endmodule

// file: axdec_checker.sv
// Checker on the decoder's bus replies, bound to its top module.
// Assumes hsel is tied high and hready is tied to hreadyout.
module axdec_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic chanA,
  input wire logic chanB,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  import axdec_pkg::*;
  logic rd;
  assign rd = hreadyout && htrans == HTRANS_NONSEQ && !hwrite;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_zero_wait: assert property (hreadyout)
    else $error("wait state inserted");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_type_width: assert property (
    rd && haddr[7:0] == OFS_TYPE |=> hrdata[31:2] == 30'h0)
    else $error("type read wider than two bits");
  a_unmapped_zero: assert property (
    rd && haddr[7:0] == 8'h0c |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_data_hold: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved without a read");
  // Status shows the pin level two synchroniser stages behind the read
  a_status_level_a: assert property (
    rd && haddr[7:0] == OFS_STATUS |=> hrdata[0] == $past(chanA, 3))
    else $error("status level A does not follow the pin");
  a_status_level_b: assert property (
    rd && haddr[7:0] == OFS_STATUS |=> hrdata[1] == $past(chanB, 3))
    else $error("status level B does not follow the pin");
  c_pos_read: cover property (rd && haddr[7:0] == OFS_POS);
  c_type_read: cover property (rd && haddr[7:0] == OFS_TYPE);
  c_back_to_back: cover property (rd ##2 rd);
endmodule

bind axdec_decoder axdec_checker u_axdec_checker (.clock(clock),
  .rst_n(rst_n), .chanA(chanA), .chanB(chanB),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// file: axdec_encoder_model.sv
// Behavioural encoder or pulse source driving both channels.
// Assumes step is called just after a rising clock edge.
module axdec_encoder_model (
  input wire logic clock,
  output logic chanA,
  output logic chanB
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {chanA, chanB} = 2'h0;
  // Each level is held 5 cycles, well over the 2-cycle minimum
  task automatic step(input logic [1:0] mode, input logic up);
    if (mode == 2'h0) begin
      // Up walks 00, 10, 11, 01 as {A,B}: A leads
      if (chanA ^ chanB ^ up) chanA <= ~chanA;
      else chanB <= ~chanB;
      repeat (5) @(posedge clock);
    end else begin
      chanA <= 1'b0;
      chanB <= mode == 2'h1 && up;
      repeat (5) @(posedge clock);
      if (mode == 2'h1 || up) chanA <= 1'b1;
      else chanB <= 1'b1;
      repeat (5) @(posedge clock);
      chanA <= 1'b0;
      chanB <= mode == 2'h1 && up;
      repeat (5) @(posedge clock);
    end
  endtask
endmodule

// file: aux_encoder_input_decoder_bench.sv
// Bench for the auxiliary encoder decoder: bus master, rows, reset.
// Assumes the encoder model produces the channel traffic.
module aux_encoder_input_decoder_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import axdec_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic up;
    logic [3:0] n;
    logic [31:0] pos;
  } axdec_row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic chanA, chanB, hready, hresp;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  int fail_count = 0, num_checks = 0;
  axdec_row_t rows [6] = '{'{2'h0, 1'b1, 4'h8, 32'h8},
    '{2'h0, 1'b0, 4'h3, 32'h5}, '{2'h1, 1'b1, 4'h4, 32'h9},
    '{2'h1, 1'b0, 4'h6, 32'h3}, '{2'h2, 1'b1, 4'h2, 32'h5},
    '{2'h2, 1'b0, 4'h7, 32'hffff_fffe}};
  initial forever #5 clock = ~clock;
  axdec_decoder u_axdec_decoder (.clock(clock), .rst_n(rst_n),
    .chanA(chanA), .chanB(chanB), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp));
  axdec_encoder_model u_axdec_encoder_model (.clock(clock),
    .chanA(chanA), .chanB(chanB));
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (rows[i]) begin
      bus(1'b1, OFS_TYPE, {30'h0, rows[i].mode});
      repeat (rows[i].n) u_axdec_encoder_model.step(rows[i].mode, rows[i].up);
      bus(1'b0, OFS_POS, 32'h0);
      chk("position", rows[i].pos, rd);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("direction", {31'h0, rows[i].up}, {31'h0, rd[STAT_DIR_UP]});
    end
    bus(1'b1, OFS_POS, 32'h55);
    bus(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, OFS_POS, 32'h0);
    chk("read-only position", 32'hffff_fffe, rd);
    // The spare type code is stored but must not move the count
    bus(1'b1, OFS_TYPE, 32'h3);
    u_axdec_encoder_model.step(2'h2, 1'b1);
    bus(1'b0, OFS_TYPE, 32'h0);
    chk("spare type", 32'h3, rd);
    bus(1'b0, OFS_POS, 32'h0);
    chk("spare type count", 32'hffff_fffe, rd);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    bus(1'b0, OFS_TYPE, 32'h0);
    chk("reset type", {30'h0, TYPE_RESET}, rd);
    u_axdec_encoder_model.step(2'h0, 1'b1);
    bus(1'b0, OFS_POS, 32'h0);
    chk("default quadrature", POS_RESET + 32'h1, rd);
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    stop_test();
  end
endmodule
